/* File: hdl/dtsp_pkg.sv */
// Constants and carrier types for the module thermal status and power throttle block
package dtsp_pkg;
	// Clock and throttling window
	localparam int CLK_NS  = 4;
	localparam int WIN_NS  = 1000;
	localparam int WIN_CYC = WIN_NS / CLK_NS;

	// Register byte offsets in configuration space
	localparam logic [11:0] STAT0_OFS = 12'h150;
	localparam logic [11:0] STAT1_OFS = 12'h154;
	localparam logic [11:0] PWR0_OFS  = 12'h190;
	localparam logic [11:0] PWR1_OFS  = 12'h192;

	// Field positions
	localparam int FLAG_LSB = 24;
	localparam int FLAG_MSB = 28;
	localparam int PEN_BIT  = 15;
	localparam int PLIM_MSB = 11;
	localparam int SENS_FRAC = 4;

	// Reset values and limits
	localparam logic [7:0]  TEMP_RST = 8'h55;
	localparam logic [7:0]  TEMP_MAX = 8'h7f;
	localparam logic        PEN_RST  = 1'h1;
	localparam logic [11:0] PLIM_RST = 12'hfff;

	// Thresholds, one bit per crossing: 4 high, 3 mid, 2 low, 1 platform low, 0 platform high
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] mid;
		logic [7:0] lo;
		logic [7:0] plat_lo;
		logic [7:0] plat_hi;
	} dtsp_thr_t;

	// Configuration access, dword address plus byte enables
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} dtsp_cfg_t;

	// Whole state of the block
	typedef struct packed {
		logic [1:0][4:0]  flag;
		logic [1:0][4:0]  cond;
		logic [1:0][7:0]  temp;
		logic [1:0]       pen;
		logic [1:0][11:0] plim;
		logic [1:0][11:0] cnt;
		logic [7:0]       win;
		logic [1:0]       allow;
		logic [31:0]      rdata;
		logic             abort;
		logic             hot_n;
		logic             sysint;
		logic [1:0][11:0] s1;
		logic [1:0][11:0] s2;
	} dtsp_state_t;
endpackage : dtsp_pkg

/* File: hdl/dtsp_top.sv */
// Thermal status flags, current temperature and power throttle for two memory modules
`timescale 1ns/1ns
module dtsp_top
	import dtsp_pkg::*;
(
	input  wire logic             clk_in,                       // 250 MHz controller clock
	input  wire logic             nrst_in,                      // Async reset, active low
	input  wire dtsp_cfg_t        cfg_in,                       // Config read/write request
	output logic [31:0]           cfg_rdata_out,                // Read data, one cycle later
	output logic                  cfg_abort_out,                // Write to locked byte aborted
	input  wire dtsp_thr_t [1:0]  thr_in,                       // Thresholds per module
	input  wire logic [1:0][4:0]  mh_en_in,                     // Alarm enable per crossing
	input  wire logic             channel_thermal_config_in,    // 1: alarm plus interrupt
	input  wire logic [1:0]       temp_source_select_in,        // 1: firmware, 0: sensor
	input  wire logic             temp_override_lock_in,        // Locks temperature byte
	input  wire logic [1:0][11:0] module_thermal_sensor_in,     // Signed, 4 fraction bits
	input  wire logic [1:0][7:0]  fw_temp_in,                   // Firmware temperature
	input  wire logic [1:0]       temp_update_in,               // Load selected source
	input  wire logic [1:0]       cmd_in,                       // ACT/READ/WRITE issued
	output logic [1:0]            cmd_allow_out,                // Command may issue
	output logic                  memory_hot_alarm_n_out,       // Alarm pin, active low
	output logic                  system_management_interrupt_out // Interrupt request
);

	dtsp_state_t     st;
	dtsp_state_t     nx;
	logic [1:0][4:0] ev;
	logic [1:0][4:0] cnd;
	logic [1:0][7:0] src;
	logic [1:0]      hit_s;
	logic            hit_p;
	logic            wend;
	logic            any_hot;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		nx      = st;
		ev      = '0;
		cnd     = '0;
		src     = '0;
		hit_s   = '0;
		any_hot = 1'b0;
		// Sensor pins cross in on two flops; sample is only taken on a load request
		nx.s1    = module_thermal_sensor_in;
		nx.s2    = st.s1;
		nx.abort = 1'b0;
		hit_p    = cfg_in.wr && (cfg_in.addr[11:2] == PWR0_OFS[11:2]);
		wend   = (st.win == 8'(WIN_CYC - 1));
		nx.win = wend ? 8'h00 : st.win + 8'h01;
		for (int m = 0; m < 2; m++) begin
			hit_s[m] = cfg_in.wr && (cfg_in.addr[11:2] == (m == 0 ? STAT0_OFS[11:2]
				: STAT1_OFS[11:2]));
			if (temp_source_select_in[m])
				src[m] = (fw_temp_in[m] > TEMP_MAX) ? TEMP_MAX : fw_temp_in[m];
			else
				src[m] = st.s2[m][11] ? 8'h00 : st.s2[m][11:SENS_FRAC];
			// rising crossings, falling below platform low
			cnd[m] = {st.temp[m] >= thr_in[m].hi, st.temp[m] >= thr_in[m].mid,
				st.temp[m] >= thr_in[m].lo, st.temp[m] < thr_in[m].plat_lo,
				st.temp[m] >= thr_in[m].plat_hi};
			ev[m]      = cnd[m] & ~st.cond[m];
			nx.cond[m] = cnd[m];
			// write one clears, a same-cycle event wins
			if (hit_s[m] && cfg_in.be[3])
				nx.flag[m] = st.flag[m] & ~cfg_in.wdata[FLAG_MSB:FLAG_LSB];
			nx.flag[m] = nx.flag[m] | ev[m];
			// locked byte rejects writes; hardware load takes priority
			if (temp_update_in[m])
				nx.temp[m] = src[m];
			else if (hit_s[m] && cfg_in.be[0]) begin
				if (temp_override_lock_in)
					nx.abort = 1'b1;
				else
					nx.temp[m] = (cfg_in.wdata[7:0] > TEMP_MAX) ? TEMP_MAX : cfg_in.wdata[7:0];
			end
			// enable and limit, two byte lanes per module
			if (hit_p && cfg_in.be[2*m])
				nx.plim[m][7:0] = cfg_in.wdata[16*m +: 8];
			if (hit_p && cfg_in.be[2*m+1]) begin
				nx.plim[m][PLIM_MSB:8] = cfg_in.wdata[16*m+8 +: 4];
				nx.pen[m]              = cfg_in.wdata[16*m+PEN_BIT];
			end
			// count issued commands, restart at window end
			if (wend)
				nx.cnt[m] = 12'h000;
			else if (cmd_in[m] && st.allow[m])
				nx.cnt[m] = st.cnt[m] + 12'h001;
			nx.allow[m] = !(nx.pen[m] && (nx.cnt[m] >= nx.plim[m]));
			any_hot = any_hot | (|(nx.flag[m] & mh_en_in[m]));
		end
		// alarm only, or alarm plus interrupt
		nx.hot_n  = !any_hot;
		nx.sysint = any_hot && channel_thermal_config_in;
		// Read data; unmapped addresses read zero
		nx.rdata = 32'h0000_0000;
		if (cfg_in.rd) begin
			if (cfg_in.addr[11:2] == STAT0_OFS[11:2])
				nx.rdata = {3'h0, st.flag[0], 16'h0000, st.temp[0]};
			else if (cfg_in.addr[11:2] == STAT1_OFS[11:2])
				nx.rdata = {3'h0, st.flag[1], 16'h0000, st.temp[1]};
			else if (cfg_in.addr[11:2] == PWR0_OFS[11:2])
				nx.rdata = {st.pen[1], 3'h0, st.plim[1], st.pen[0], 3'h0, st.plim[0]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st        <= '0;
			st.temp   <= {TEMP_RST, TEMP_RST};
			st.pen    <= {PEN_RST, PEN_RST};
			st.plim   <= {PLIM_RST, PLIM_RST};
			st.allow  <= 2'h3;
			st.hot_n  <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	// Outputs straight from the state flops
	assign cfg_rdata_out                   = st.rdata;
	assign cfg_abort_out                   = st.abort;
	assign cmd_allow_out                   = st.allow;
	assign memory_hot_alarm_n_out          = st.hot_n;
	assign system_management_interrupt_out = st.sysint;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	AST_HI_SET: assert property (ev[0][4] |=> st.flag[0][4])
		else $error("high flag not set");
	AST_MID_SET: assert property (ev[0][3] |=> st.flag[0][3])
		else $error("mid flag not set");
	AST_LO_SET: assert property (ev[0][2] |=> st.flag[0][2])
		else $error("low flag not set");
	AST_PLO_FALL: assert property (ev[0][1] |-> st.temp[0] < thr_in[0].plat_lo ##1 st.flag[0][1])
		else $error("platform low flag wrong");
	AST_PHI_SET: assert property (ev[0][0] |=> st.flag[0][0])
		else $error("platform high flag not set");
	AST_ALARM: assert property (any_hot |=> !memory_hot_alarm_n_out
		&& system_management_interrupt_out == $past(channel_thermal_config_in))
		else $error("alarm or interrupt missing");
	AST_LOCK: assert property (cfg_in.wr && cfg_in.addr == STAT0_OFS && cfg_in.be[0]
		&& temp_override_lock_in && !temp_update_in[0]
		|=> cfg_abort_out && $stable(st.temp[0]))
		else $error("locked temperature write not aborted");
	AST_RANGE: assert property (st.temp[0] <= TEMP_MAX && st.temp[1] <= TEMP_MAX)
		else $error("temperature out of range");
	AST_WIN: assert property (wend |=> st.cnt[0] == 12'h000 && st.win == 8'h00)
		else $error("window did not restart");
	// Count must not creep past the limit inside a window
	AST_HOLD: assert property (st.pen[0] && st.cnt[0] >= st.plim[0] && !wend && !hit_p
		|=> !cmd_allow_out[0] && $stable(st.cnt[0]))
		else $error("command allowed past limit");

	COV_HI: cover property (ev[0][4] ##1 !memory_hot_alarm_n_out);
	COV_THROTTLE: cover property (!cmd_allow_out[0] ##[1:250] cmd_allow_out[0]);
	COV_ABORT: cover property (cfg_abort_out);
endmodule : dtsp_top

/* File: dv/dtsp_top_tb.sv */
// Self-checking bench for the module thermal status and power throttle block
`timescale 1ns/1ns
module dtsp_top_tb
	import dtsp_pkg::*;
;
	logic             clk_in, nrst_in, lock, cfg30;
	dtsp_cfg_t        cfg_in;
	logic [31:0]      rdata;
	logic             abort, alarm_n, system_management_interrupt;
	logic [1:0]       src, upd, cmd, allow;
	logic [1:0][11:0] sens;
	logic [1:0][7:0]  fw;
	dtsp_thr_t [1:0]  thr;
	int               n_mismatch, checks, seed, na0, na1;
	logic [31:0]      q_rd[$];
	logic             q_ab[$];
	logic             mon_rd = 1'b0;
	logic             mon_wr = 1'b0;
	logic [11:0]      lim;
	logic [1:0][4:0]  mh_en;

	////////////////////////////////////////////////////////////////////////////
	// Clock, design and watchdog
	always #2 clk_in = ~clk_in;
	dtsp_top i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .cfg_in(cfg_in),
		.cfg_rdata_out(rdata), .cfg_abort_out(abort), .thr_in(thr),
		.mh_en_in(mh_en), .channel_thermal_config_in(cfg30),
		.temp_source_select_in(src), .temp_override_lock_in(lock),
		.module_thermal_sensor_in(sens), .fw_temp_in(fw), .temp_update_in(upd),
		.cmd_in(cmd), .cmd_allow_out(allow), .memory_hot_alarm_n_out(alarm_n),
		.system_management_interrupt_out(system_management_interrupt));
	// Cut a hang short, run needs well under 3000 cycles
	initial begin
		#20000;
		n_mismatch++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// One access, expectation queued; idle gap lets flags settle
	task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] b,
		input logic [31:0] d);
		@(posedge clk_in);
		cfg_in <= '{w, !w, a, b, d};
		if (w) q_ab.push_back(lock && b[0] && (a == STAT0_OFS || a == STAT1_OFS));
		else q_rd.push_back(d);
		@(posedge clk_in);
		cfg_in <= '0;
		repeat (3) @(posedge clk_in);
	endtask : acc
	// Present a source, wait out the synchroniser, pulse the load
	task automatic load(input logic s, input logic [11:0] v, input logic [7:0] f);
		@(posedge clk_in);
		src <= {1'b0, s};
		sens[0] <= v;
		fw[0] <= f;
		repeat (4) @(posedge clk_in);
		upd <= 2'b01;
		@(posedge clk_in);
		upd <= 2'b00;
		repeat (3) @(posedge clk_in);
	endtask : load
	// Count allowed cycles over one window, aligned on module 0 reopening
	task automatic win(input int e0, input int e1);
		logic prev;
		prev = 1'b1;
		@(posedge clk_in);
		cmd <= 2'b11;
		for (int i = 0; i < 600; i++) begin
			@(negedge clk_in);
			if (allow[0] === 1'b1 && prev === 1'b0) break;
			prev = allow[0];
		end
		na0 = 0;
		na1 = 0;
		repeat (250) begin
			na0 += (allow[0] === 1'b1);
			na1 += (allow[1] === 1'b1);
			@(negedge clk_in);
		end
		chk(na0, e0); // limit reached
		chk(na1, e1); // enable
		@(posedge clk_in);
		cmd <= 2'b00;
	endtask : win
	task automatic end_of_test();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////////
	// Monitor: oldest note taken off as each result appears
	always @(posedge clk_in) begin
		mon_rd <= cfg_in.rd;
		mon_wr <= cfg_in.wr;
	end
	always @(negedge clk_in) begin
		if (mon_rd) chk(rdata, q_rd.pop_front()); // Read data
		if (mon_wr) chk({31'h0, abort}, {31'h0, q_ab.pop_front()}); // Abort
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequence; thresholds other than platform low sit above 0x55, platform low sits below it, so reset fires nothing
	initial begin
		seed = 32'h8c4d;
		{clk_in, nrst_in, lock, upd, cmd, src, sens, fw} = '0;
		cfg_in = '0;
		cfg30 = 1'b1;
		mh_en = 10'h010;
		thr[0] = '{8'h70, 8'h60, 8'h58, 8'h20, 8'h56};
		thr[1] = thr[0];
		repeat (12) @(posedge clk_in);
		nrst_in <= 1'b1;
		acc(0, STAT1_OFS, 4'hf, 32'h55); // reset
		acc(0, PWR0_OFS, 4'hf, 32'h8fff8fff); // reset
		acc(0, 12'h160, 4'hf, 32'h0);
		load(0, 12'h2a8, 8'h00);
		acc(0, STAT0_OFS, 4'hf, 32'h2a); // truncation
		load(1, 12'h2a8, 8'h33);
		acc(0, STAT0_OFS, 4'hf, 32'h33); // firmware source
		acc(1, STAT0_OFS, 4'h1, 32'h44);
		lock <= 1'b1;
		acc(1, STAT0_OFS, 4'h1, 32'h11);
		acc(0, STAT0_OFS, 4'hf, 32'h44); // locked byte kept
		lock <= 1'b0;
		acc(1, STAT0_OFS, 4'h1, 32'hff);
		acc(0, STAT0_OFS, 4'hf, 32'h1d00007f);
		@(negedge clk_in);
		chk({alarm_n, system_management_interrupt}, 32'h1); // alarm plus interrupt
		load(0, 12'hf80, 8'h00);
		acc(0, STAT0_OFS, 4'hf, 32'h1f000000);
		acc(1, STAT0_OFS, 4'h8, 32'h10000000);
		acc(0, STAT0_OFS, 4'hf, 32'h0f000000); // clear
		@(negedge clk_in);
		chk({alarm_n, system_management_interrupt}, 32'h2); // disabled flags silent
		cfg30 <= 1'b0;
		acc(1, STAT0_OFS, 4'h8, 32'h0f000000);
		acc(1, STAT0_OFS, 4'h1, 32'h7f);
		@(negedge clk_in);
		chk({alarm_n, system_management_interrupt}, 32'h0); // alarm only
		// Throttle with a random limit, module 1 blocked by limit zero
		lim = 12'(32'd1 + ($random(seed) & 32'd7));
		acc(1, PWR0_OFS, 4'hf, {16'hf000, 4'hf, lim});
		acc(0, PWR0_OFS, 4'hf, {16'h8000, 4'h8, lim});
		win(lim, 0);
		acc(1, PWR0_OFS, 4'hc, 32'h0);
		win(lim, 250);
		// Mid-run reset must bring back the reset values and drop the alarm
		@(posedge clk_in);
		nrst_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		acc(0, STAT0_OFS, 4'hf, 32'h55); // reset after run
		acc(0, PWR0_OFS, 4'hf, 32'h8fff8fff); // reset after run
		@(negedge clk_in);
		chk({alarm_n, system_management_interrupt}, 32'h2); // alarm clears with flags
		end_of_test();
	end
endmodule : dtsp_top_tb
